// ===== rtl/u0pr_pin_mux.v
`include "u0pr_defines.vh"

module u0pr_pin_mux (
   input wire clk_in,
   input wire reset_n_in,
   input wire ce_in,
   input wire [`U0PR_ADDR_W-1:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [`U0PR_DATA_W-1:0] avs_writedata_in,
   input wire [`U0PR_BE_W-1:0] avs_byteenable_in,
   output wire [`U0PR_DATA_W-1:0] avs_readdata_out,
   output wire avs_waitrequest_out,
   input wire serial0_transmit_in,
   input wire serial0_rx_mode_in,
   output wire serial0_receive_out,
   input wire [`U0PR_P0_W-1:0] port0_pin_in,
   input wire [`U0PR_P4_W-1:0] port4_pin_in,
   output wire [`U0PR_P4_W-1:0] port4_pin_out,
   output wire [`U0PR_P4_W-1:0] port4_pin_oe_n_out
);

   // Software-visible configuration.
   reg [`U0PR_REG_W-1:0] port0_data_out_ff;
   reg [`U0PR_REG_W-1:0] port0_drive_ctrl_lo_ff;
   reg [`U0PR_REG_W-1:0] port0_drive_ctrl_hi_ff;
   reg [`U0PR_REG_W-1:0] port4_data_out_ff;
   reg [`U0PR_REG_W-1:0] port4_direction_ff;
   reg [`U0PR_REG_W-1:0] port4_drive_ctrl_lo_ff;
   reg [`U0PR_REG_W-1:0] port4_drive_ctrl_hi_ff;
   reg [`U0PR_REG_W-1:0] port4_function_sel_lo_ff;
   reg [`U0PR_REG_W-1:0] port4_function_sel_hi_ff;
   reg [`U0PR_REG_W-1:0] serial0_mode_reg0_ff;

   // Bus slave state.
   reg waitreq_ff;
   reg [`U0PR_DATA_W-1:0] readdata_ff;
   reg nxt_waitreq;
   reg [`U0PR_DATA_W-1:0] nxt_readdata;
   reg [`U0PR_REG_W-1:0] rd_byte;

   // Pin-facing state.
   reg [`U0PR_P4_W-1:0] pin_out_ff;
   reg [`U0PR_P4_W-1:0] pin_oe_n_ff;
   reg receive_ff;
   reg [`U0PR_P4_W-1:0] nxt_pin_out;
   reg [`U0PR_P4_W-1:0] nxt_pin_oe_n;
   reg nxt_receive;
   reg [`U0PR_P4_W-1:0] pin_level;
   reg [1:0] drv_pair;
   integer i;

   // Decoded conditions.
   wire req;
   wire wr_commit;
   wire wr_low_byte;
   wire tx_routed;
   wire alt_rx_routed;
   wire rx_sel;
   wire tx_level;
   wire alt_rx_ready;
   wire [`U0PR_P0_W-1:0] port0_level;
   wire [`U0PR_P4_W-1:0] port4_level;
   wire [`U0PR_REG_W-1:0] route_status;

   // True when the byte address hits the word of the given register index.
   function reg_hit;
      input [`U0PR_ADDR_W-1:0] addr;
      input [`U0PR_IDX_W-1:0] idx;
      begin
         reg_hit = (addr == {idx, 2'h0});
      end
   endfunction

   // True when a pin's mode bits pick the serial secondary function.
   function is_serial;
      input hi_bit;
      input lo_bit;
      begin
         is_serial = ({hi_bit, lo_bit} == `U0PR_FUNC_SERIAL);
      end
   endfunction

   // Pin driver: returns {oe_n, level}. Direction 1 makes an input; with
   // direction 0 both drive bits set give push-pull, one set gives an
   // open-drain driver that only pulls low, neither gives high impedance.
   function [1:0] pin_drive;
      input dir_bit;
      input drv_hi;
      input drv_lo;
      input level;
      begin
         if (dir_bit == `U0PR_DIR_INPUT) begin
            pin_drive = 2'h2;
         end else begin
            case ({drv_hi, drv_lo})
               `U0PR_DRV_CMOS: pin_drive = {1'b0, level};
               `U0PR_DRV_OD_A: pin_drive = {level, 1'b0};
               `U0PR_DRV_OD_B: pin_drive = {level, 1'b0};
               default: pin_drive = 2'h2;
            endcase
         end
      end
   endfunction

   // Both pin groups come from outside the clock domain and are synchronised.
   u0pr_sync #(
      .WIDTH(`U0PR_P0_W),
      .RESET_VAL({`U0PR_P0_W{1'b1}})
   ) u_sync_port0 (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .ce_in(ce_in),
      .async_in(port0_pin_in),
      .stable_out(port0_level)
   );

   u0pr_sync #(
      .WIDTH(`U0PR_P4_W),
      .RESET_VAL({`U0PR_P4_W{1'b1}})
   ) u_sync_port4 (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .ce_in(ce_in),
      .async_in(port4_pin_in),
      .stable_out(port4_level)
   );

   // Bus handshake: a request is answered one cycle after it is first seen,
   // and a write lands only at the edge where waitrequest is sampled low.
   assign req = avs_read_in | avs_write_in;
   assign wr_commit = avs_write_in & ~waitreq_ff;
   assign wr_low_byte = wr_commit & avs_byteenable_in[`U0PR_BIT_BE_LOW];

   // Transmit routing looks only at bit 3's own mode bits.
   assign tx_routed = is_serial(port4_function_sel_hi_ff[`U0PR_BIT_TX],
                                port4_function_sel_lo_ff[`U0PR_BIT_TX]);
   assign alt_rx_ready = is_serial(port4_function_sel_hi_ff[`U0PR_BIT_ALT_RX],
                                   port4_function_sel_lo_ff[`U0PR_BIT_ALT_RX]) &
                         (port4_direction_ff[`U0PR_BIT_ALT_RX] == `U0PR_DIR_INPUT);
   assign rx_sel = serial0_mode_reg0_ff[`U0PR_BIT_RX_SEL];
   assign alt_rx_routed = rx_sel;

   // The transmitter idles high whenever the channel is set to receive.
   assign tx_level = serial0_rx_mode_in ? 1'b1 : serial0_transmit_in;

   assign route_status = {{(`U0PR_REG_W - 4){1'b0}}, alt_rx_ready, alt_rx_routed, tx_routed, receive_ff};

   assign avs_readdata_out = readdata_ff;
   assign avs_waitrequest_out = waitreq_ff;
   assign port4_pin_out = pin_out_ff;
   assign port4_pin_oe_n_out = pin_oe_n_ff;
   assign serial0_receive_out = receive_ff;

   // Read mux; unmapped words read as zero and upper bytes are always zero.
   always @* begin
      rd_byte = {`U0PR_REG_W{1'b0}};
      if (reg_hit(avs_address_in, `U0PR_IDX_PORT0_DATA_OUT)) begin
         rd_byte = port0_data_out_ff;
      end else if (reg_hit(avs_address_in, `U0PR_IDX_PORT0_DRIVE_LO)) begin
         rd_byte = port0_drive_ctrl_lo_ff;
      end else if (reg_hit(avs_address_in, `U0PR_IDX_PORT0_DRIVE_HI)) begin
         rd_byte = port0_drive_ctrl_hi_ff;
      end else if (reg_hit(avs_address_in, `U0PR_IDX_PORT4_DATA_OUT)) begin
         rd_byte = port4_data_out_ff;
      end else if (reg_hit(avs_address_in, `U0PR_IDX_PORT4_DIRECTION)) begin
         rd_byte = port4_direction_ff;
      end else if (reg_hit(avs_address_in, `U0PR_IDX_PORT4_DRIVE_LO)) begin
         rd_byte = port4_drive_ctrl_lo_ff;
      end else if (reg_hit(avs_address_in, `U0PR_IDX_PORT4_DRIVE_HI)) begin
         rd_byte = port4_drive_ctrl_hi_ff;
      end else if (reg_hit(avs_address_in, `U0PR_IDX_PORT4_FUNC_LO)) begin
         rd_byte = port4_function_sel_lo_ff;
      end else if (reg_hit(avs_address_in, `U0PR_IDX_PORT4_FUNC_HI)) begin
         rd_byte = port4_function_sel_hi_ff;
      end else if (reg_hit(avs_address_in, `U0PR_IDX_SERIAL0_MODE0)) begin
         rd_byte = serial0_mode_reg0_ff;
      end else if (reg_hit(avs_address_in, `U0PR_IDX_ROUTE_STATUS)) begin
         rd_byte = route_status;
      end else if (reg_hit(avs_address_in, `U0PR_IDX_PORT4_LEVEL)) begin
         rd_byte = port4_level;
      end else if (reg_hit(avs_address_in, `U0PR_IDX_PORT0_LEVEL)) begin
         rd_byte = {{(`U0PR_REG_W - `U0PR_P0_W){1'b0}}, port0_level};
      end
   end

   // Waitrequest drops for exactly one cycle per request, then rises again
   // so that a held request is not answered again at the next edge.
   always @* begin
      nxt_waitreq = ~(req & waitreq_ff);
      nxt_readdata = readdata_ff;
      if (avs_read_in & waitreq_ff) begin
         nxt_readdata = {{(`U0PR_DATA_W - `U0PR_REG_W){1'b0}}, rd_byte};
      end
   end

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         waitreq_ff <= 1'b1;
         readdata_ff <= {`U0PR_DATA_W{1'b0}};
      end else if (ce_in) begin
         waitreq_ff <= nxt_waitreq;
         readdata_ff <= nxt_readdata;
      end
   end

   // Register writes. Port 0 has no direction register at all, since its
   // pins are input only.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port0_data_out_ff <= `U0PR_RST_DATA;
         port0_drive_ctrl_lo_ff <= `U0PR_RST_DRIVE;
         port0_drive_ctrl_hi_ff <= `U0PR_RST_DRIVE;
         port4_data_out_ff <= `U0PR_RST_DATA;
         port4_direction_ff <= `U0PR_RST_DIR;
         port4_drive_ctrl_lo_ff <= `U0PR_RST_DRIVE;
         port4_drive_ctrl_hi_ff <= `U0PR_RST_DRIVE;
         port4_function_sel_lo_ff <= `U0PR_RST_FUNC;
         port4_function_sel_hi_ff <= `U0PR_RST_FUNC;
         serial0_mode_reg0_ff <= `U0PR_RST_MODE0;
      end else if (ce_in && wr_low_byte) begin
         if (reg_hit(avs_address_in, `U0PR_IDX_PORT0_DATA_OUT)) begin
            port0_data_out_ff <= avs_writedata_in[`U0PR_REG_W-1:0];
         end
         if (reg_hit(avs_address_in, `U0PR_IDX_PORT0_DRIVE_LO)) begin
            port0_drive_ctrl_lo_ff <= avs_writedata_in[`U0PR_REG_W-1:0];
         end
         if (reg_hit(avs_address_in, `U0PR_IDX_PORT0_DRIVE_HI)) begin
            port0_drive_ctrl_hi_ff <= avs_writedata_in[`U0PR_REG_W-1:0];
         end
         if (reg_hit(avs_address_in, `U0PR_IDX_PORT4_DATA_OUT)) begin
            port4_data_out_ff <= avs_writedata_in[`U0PR_REG_W-1:0];
         end
         if (reg_hit(avs_address_in, `U0PR_IDX_PORT4_DIRECTION)) begin
            port4_direction_ff <= avs_writedata_in[`U0PR_REG_W-1:0];
         end
         if (reg_hit(avs_address_in, `U0PR_IDX_PORT4_DRIVE_LO)) begin
            port4_drive_ctrl_lo_ff <= avs_writedata_in[`U0PR_REG_W-1:0];
         end
         if (reg_hit(avs_address_in, `U0PR_IDX_PORT4_DRIVE_HI)) begin
            port4_drive_ctrl_hi_ff <= avs_writedata_in[`U0PR_REG_W-1:0];
         end
         if (reg_hit(avs_address_in, `U0PR_IDX_PORT4_FUNC_LO)) begin
            port4_function_sel_lo_ff <= avs_writedata_in[`U0PR_REG_W-1:0];
         end
         if (reg_hit(avs_address_in, `U0PR_IDX_PORT4_FUNC_HI)) begin
            port4_function_sel_hi_ff <= avs_writedata_in[`U0PR_REG_W-1:0];
         end
         if (reg_hit(avs_address_in, `U0PR_IDX_SERIAL0_MODE0)) begin
            serial0_mode_reg0_ff <= avs_writedata_in[`U0PR_REG_W-1:0];
         end
      end
   end

   // Pin drivers. Bit 3, when serial, takes its level from the channel and never
   // from the data register; every other pin is an ordinary port bit. The
   // drive bits shape only the driver, so they never gate reception.
   always @* begin
      pin_level = port4_data_out_ff;
      if (tx_routed) begin
         pin_level[`U0PR_BIT_TX] = tx_level;
      end
      nxt_pin_out = {`U0PR_P4_W{1'b0}};
      nxt_pin_oe_n = {`U0PR_P4_W{1'b1}};
      drv_pair = 2'h2;
      for (i = 0; i < `U0PR_P4_W; i = i + 1) begin
         drv_pair = pin_drive(port4_direction_ff[i], port4_drive_ctrl_hi_ff[i],
                              port4_drive_ctrl_lo_ff[i], pin_level[i]);
         nxt_pin_oe_n[i] = drv_pair[1];
         nxt_pin_out[i] = drv_pair[0];
      end
   end

   // Receive source: the select bit alone decides, so a fully configured
   // port-4 bit 2 is bypassed while the bit is 0. Neither data register nor
   // any drive bit enters this path.
   always @* begin
      if (rx_sel) begin
         nxt_receive = port4_level[`U0PR_BIT_ALT_RX];
      end else begin
         nxt_receive = port0_level[`U0PR_BIT_DEF_RX];
      end
   end

   // Output registers; the pins start as inputs and the line idles high.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin_out_ff <= {`U0PR_P4_W{1'b0}};
         pin_oe_n_ff <= {`U0PR_P4_W{1'b1}};
         receive_ff <= 1'b1;
      end else if (ce_in) begin
         pin_out_ff <= nxt_pin_out;
         pin_oe_n_ff <= nxt_pin_oe_n;
         receive_ff <= nxt_receive;
      end
   end

endmodule

// ===== inc/u0pr_defines.vh
`ifndef U0PR_DEFINES_VH
`define U0PR_DEFINES_VH

// Bus geometry: byte address, one aligned 32-bit word per register.
`define U0PR_ADDR_W 18
`define U0PR_DATA_W 32
`define U0PR_BE_W 4
`define U0PR_IDX_W 16
`define U0PR_REG_W 8

// Register indices; the byte address is four times the index.
`define U0PR_IDX_PORT0_DATA_OUT 16'hF204
`define U0PR_IDX_PORT0_DRIVE_LO 16'hF206
`define U0PR_IDX_PORT0_DRIVE_HI 16'hF207
`define U0PR_IDX_PORT4_DATA_OUT 16'hF220
`define U0PR_IDX_PORT4_DIRECTION 16'hF221
`define U0PR_IDX_PORT4_DRIVE_LO 16'hF222
`define U0PR_IDX_PORT4_DRIVE_HI 16'hF223
`define U0PR_IDX_PORT4_FUNC_LO 16'hF224
`define U0PR_IDX_PORT4_FUNC_HI 16'hF225
`define U0PR_IDX_SERIAL0_MODE0 16'hF2A0
`define U0PR_IDX_ROUTE_STATUS 16'hF2A1
`define U0PR_IDX_PORT4_LEVEL 16'hF2A2
`define U0PR_IDX_PORT0_LEVEL 16'hF2A3

// Reset values of the writable registers.
`define U0PR_RST_DATA 8'h00
`define U0PR_RST_DIR 8'hFF
`define U0PR_RST_DRIVE 8'h00
`define U0PR_RST_FUNC 8'h00
`define U0PR_RST_MODE0 8'h00

// Field positions.
`define U0PR_BIT_TX 3
`define U0PR_BIT_ALT_RX 2
`define U0PR_BIT_DEF_RX 2
`define U0PR_BIT_RX_SEL 4
`define U0PR_BIT_BE_LOW 0
`define U0PR_ST_RX_LEVEL 0
`define U0PR_ST_TX_ROUTED 1
`define U0PR_ST_RX_FROM_ALT 2
`define U0PR_ST_ALT_RX_READY 3

// Pin function codes {high mode bit, low mode bit}.
`define U0PR_FUNC_PORT 2'h0
`define U0PR_FUNC_SERIAL 2'h1

// Output drive codes {high drive bit, low drive bit}.
`define U0PR_DRV_HIZ 2'h0
`define U0PR_DRV_OD_A 2'h1
`define U0PR_DRV_OD_B 2'h2
`define U0PR_DRV_CMOS 2'h3

// Direction bit value that makes a pin an input.
`define U0PR_DIR_INPUT 1'h1

// Widths of the pin groups.
`define U0PR_P0_W 4
`define U0PR_P4_W 8

`endif

// ===== rtl/u0pr_sync.v
`include "u0pr_defines.vh"

// Three-stage input synchroniser with agreement filter.
// A new level is accepted only once the second and third stages agree, so a
// single metastable sample never reaches the logic behind it.
module u0pr_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   input wire clk_in,
   input wire reset_n_in,
   input wire ce_in,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] stable_out
);

   reg [WIDTH-1:0] stage1_ff;
   reg [WIDTH-1:0] stage2_ff;
   reg [WIDTH-1:0] stage3_ff;
   reg [WIDTH-1:0] stable_ff;
   wire [WIDTH-1:0] agree;
   wire [WIDTH-1:0] nxt_stable;

   // Only stages two and three are compared; stage one feeds stage two alone.
   assign agree = ~(stage2_ff ^ stage3_ff);
   assign nxt_stable = (stage2_ff & agree) | (stable_ff & ~agree);
   assign stable_out = stable_ff;

   // Shift chain and filtered output, frozen while the clock enable is low.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         stage1_ff <= RESET_VAL;
         stage2_ff <= RESET_VAL;
         stage3_ff <= RESET_VAL;
         stable_ff <= RESET_VAL;
      end else if (ce_in) begin
         stage1_ff <= async_in;
         stage2_ff <= stage1_ff;
         stage3_ff <= stage2_ff;
         stable_ff <= nxt_stable;
      end
   end

endmodule

// ===== sim/u0pr_monitor.sv
`include "u0pr_defines.vh"

// Port-level checker; it shadows the port-4 and serial mode registers from completed bus writes.
module u0pr_monitor (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic ce_in,
   input wire logic [`U0PR_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [`U0PR_DATA_W-1:0] avs_writedata_in,
   input wire logic [`U0PR_BE_W-1:0] avs_byteenable_in,
   input wire logic avs_waitrequest_out,
   input wire logic serial0_transmit_in,
   input wire logic serial0_rx_mode_in,
   input wire logic serial0_receive_out,
   input wire logic [`U0PR_P0_W-1:0] port0_pin_in,
   input wire logic [`U0PR_P4_W-1:0] port4_pin_in,
   input wire logic [`U0PR_P4_W-1:0] port4_pin_out,
   input wire logic [`U0PR_P4_W-1:0] port4_pin_oe_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] dat_ff, dir_ff, dlo_ff, dhi_ff, flo_ff, fhi_ff, mode_ff;
   wire wr_done = ce_in && avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
   wire [15:0] widx = avs_address_in[17:2];
   wire tx_sec = !fhi_ff[3] && flo_ff[3];
   wire tx_pp = !dir_ff[3] && dhi_ff[3] && dlo_ff[3];
   wire tx_lvl = serial0_rx_mode_in ? 1'b1 : serial0_transmit_in;
   wire rx_alt = mode_ff[`U0PR_BIT_RX_SEL];

   // The shadow updates at the same edge as the design, so one-edge output lag applies to both.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dat_ff <= `U0PR_RST_DATA;
         dir_ff <= `U0PR_RST_DIR;
         dlo_ff <= `U0PR_RST_DRIVE;
         dhi_ff <= `U0PR_RST_DRIVE;
         flo_ff <= `U0PR_RST_FUNC;
         fhi_ff <= `U0PR_RST_FUNC;
         mode_ff <= `U0PR_RST_MODE0;
      end else if (wr_done) begin
         case (widx)
            `U0PR_IDX_PORT4_DATA_OUT: dat_ff <= avs_writedata_in[7:0];
            `U0PR_IDX_PORT4_DIRECTION: dir_ff <= avs_writedata_in[7:0];
            `U0PR_IDX_PORT4_DRIVE_LO: dlo_ff <= avs_writedata_in[7:0];
            `U0PR_IDX_PORT4_DRIVE_HI: dhi_ff <= avs_writedata_in[7:0];
            `U0PR_IDX_PORT4_FUNC_LO: flo_ff <= avs_writedata_in[7:0];
            `U0PR_IDX_PORT4_FUNC_HI: fhi_ff <= avs_writedata_in[7:0];
            `U0PR_IDX_SERIAL0_MODE0: mode_ff <= avs_writedata_in[7:0];
            default: ;
         endcase
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in || !ce_in);

   // Seven steady samples cover the four-flop filter plus the output register.
   sequence seq_def_hold(bit v);
      (!rx_alt && port0_pin_in[`U0PR_BIT_DEF_RX] == v) [*7];
   endsequence
   sequence seq_alt_hold(bit v);
      (rx_alt && port4_pin_in[`U0PR_BIT_ALT_RX] == v) [*7];
   endsequence

   chk_rx_def_high: assert property (seq_def_hold(1'b1) |-> serial0_receive_out)
      else $error("receive does not follow default pin high");
   chk_rx_def_low: assert property (seq_def_hold(1'b0) |-> !serial0_receive_out)
      else $error("receive does not follow default pin low");
   chk_rx_alt_high: assert property (seq_alt_hold(1'b1) |-> serial0_receive_out)
      else $error("receive does not follow alternate pin high");
   chk_rx_alt_low: assert property (seq_alt_hold(1'b0) |-> !serial0_receive_out)
      else $error("receive does not follow alternate pin low");
   chk_tx_level: assert property (tx_sec && tx_pp |=> port4_pin_out[3] == $past(tx_lvl))
      else $error("transmit pin level wrong");
   chk_tx_drive: assert property (tx_sec && tx_pp |=> !port4_pin_oe_n_out[3])
      else $error("transmit pin not driven");
   chk_tx_rx_high: assert property (tx_sec && tx_pp && serial0_rx_mode_in |=> port4_pin_out[3])
      else $error("transmit pin not high in receive mode");
   chk_port_keep: assert property (!tx_sec && tx_pp |=> port4_pin_out[3] == $past(dat_ff[3]))
      else $error("port pin does not show its data bit");
   chk_alt_input: assert property (dir_ff[2] |=> port4_pin_oe_n_out[2])
      else $error("alternate receive pin driven while input");
   chk_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("bus answer late");
   chk_bus_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");
endmodule

bind u0pr_pin_mux u0pr_monitor u0pr_monitor_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_waitrequest_out(avs_waitrequest_out), .serial0_transmit_in(serial0_transmit_in),
   .serial0_rx_mode_in(serial0_rx_mode_in), .serial0_receive_out(serial0_receive_out),
   .port0_pin_in(port0_pin_in), .port4_pin_in(port4_pin_in), .port4_pin_out(port4_pin_out),
   .port4_pin_oe_n_out(port4_pin_oe_n_out));

// ===== sim/u0pr_serial_peer.sv
// External serial device and board: resolves the port-4 lines and drives the receive lines.
module u0pr_serial_peer (
   input wire logic [7:0] pin_out_in,
   input wire logic [7:0] pin_oe_n_in,
   input wire logic alt_rx_level_in,
   input wire logic def_rx_level_in,
   output logic [7:0] pin_wire_out,
   output logic [3:0] port0_wire_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Every port-4 line except bit 2 has a board pull-up, so it reads high when undriven; an undriven bit 2 reads the alternate receive level.
   always_comb begin
      for (int i = 0; i < 8; i++) pin_wire_out[i] = pin_oe_n_in[i] ? 1'b1 : pin_out_in[i];
      if (pin_oe_n_in[2]) pin_wire_out[2] = alt_rx_level_in;
      port0_wire_out = {1'b1, def_rx_level_in, 2'h3};
   end
endmodule

// ===== sim/tb_top.sv
`include "u0pr_defines.vh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in, reset_n_in, tx, rxm, alt_lvl, def_lvl, rd, wr, ce;
   logic [17:0] addr;
   logic [31:0] wdata;
   logic [3:0] be;
   wire [31:0] rdata;
   wire waitreq, rx_out;
   wire [7:0] p4_out, p4_oe_n, p4_wire;
   wire [3:0] p0_wire;
   int error_cnt, num_checks, cyc;
   logic [15:0] idx_t [10] = '{`U0PR_IDX_PORT0_DATA_OUT, `U0PR_IDX_PORT0_DRIVE_LO, `U0PR_IDX_PORT0_DRIVE_HI,
      `U0PR_IDX_PORT4_DATA_OUT, `U0PR_IDX_PORT4_DIRECTION, `U0PR_IDX_PORT4_DRIVE_LO, `U0PR_IDX_PORT4_DRIVE_HI,
      `U0PR_IDX_PORT4_FUNC_LO, `U0PR_IDX_PORT4_FUNC_HI, `U0PR_IDX_SERIAL0_MODE0};
   logic [7:0] rst_t [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   u0pr_pin_mux u0pr_pin_mux_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
      .serial0_transmit_in(tx), .serial0_rx_mode_in(rxm), .serial0_receive_out(rx_out),
      .port0_pin_in(p0_wire), .port4_pin_in(p4_wire), .port4_pin_out(p4_out), .port4_pin_oe_n_out(p4_oe_n));
   u0pr_serial_peer u0pr_serial_peer_i (.pin_out_in(p4_out), .pin_oe_n_in(p4_oe_n), .alt_rx_level_in(alt_lvl),
      .def_rx_level_in(def_lvl), .pin_wire_out(p4_wire), .port0_wire_out(p0_wire));

   // Free-running clock at 200 MHz.
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   // Watchdog: the run needs a few hundred cycles, so this ceiling only catches a hang.
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task give_verdict;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // One bus cycle; the request is held until waitrequest is sampled low, then released.
   task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_in);
      addr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      wr <= w;
      rd <= !w;
      @(posedge clk_in);
      while (waitreq !== 1'b0) @(posedge clk_in);
      q = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic wreg(input logic [15:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, q);
   endtask

   task automatic rchk(input logic [15:0] idx, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, idx, 8'h00, q);
      check(q, e);
   endtask

   task automatic pin_chk(input logic seen, input logic e);
      check({7'h00, seen}, {7'h00, e});
   endtask

   // Main sequence: registers first, then transmit routing, then receive selection.
   initial begin
      {reset_n_in, tx, rxm, rd, wr, addr, wdata} = '0;
      {alt_lvl, def_lvl, be, ce} = {2'b11, 4'h1, 1'b1};
      repeat (4) @(posedge clk_in);
      reset_n_in <= 1'b1;
      foreach (idx_t[i]) rchk(idx_t[i], rst_t[i]);
      foreach (idx_t[i]) begin
         wreg(idx_t[i], 8'hA5 ^ 8'(i));
         rchk(idx_t[i], 8'hA5 ^ 8'(i));
      end
      wreg(16'hF2FF, 8'h5A);
      rchk(16'hF2FF, 8'h00);
      be <= 4'h0;
      wreg(idx_t[0], 8'h33);
      be <= 4'h1;
      rchk(idx_t[0], 8'hA5);
      wreg(`U0PR_IDX_PORT4_FUNC_HI, 8'h00);
      wreg(`U0PR_IDX_PORT4_DRIVE_HI, 8'h08);
      wreg(`U0PR_IDX_PORT4_DRIVE_LO, 8'h08);
      wreg(`U0PR_IDX_PORT4_DIRECTION, 8'h04);
      wreg(`U0PR_IDX_PORT4_DATA_OUT, 8'h08);
      for (int f = 0; f < 2; f++) begin
         wreg(`U0PR_IDX_PORT4_FUNC_LO, f ? 8'h0C : 8'h08);
         for (int v = 0; v < 2; v++) begin
            tx <= v[0];
            repeat (3) @(posedge clk_in);
            pin_chk(p4_wire[3], v[0]);
            pin_chk(p4_oe_n[3], 1'b0);
         end
      end
      rxm <= 1'b1;
      tx <= 1'b0;
      repeat (3) @(posedge clk_in);
      pin_chk(p4_wire[3], 1'b1);
      // With the clock enable low the pin must hold its level; it moves once enabled again.
      ce <= 1'b0;
      rxm <= 1'b0;
      repeat (3) @(posedge clk_in);
      pin_chk(p4_wire[3], 1'b1);
      ce <= 1'b1;
      repeat (3) @(posedge clk_in);
      pin_chk(p4_wire[3], 1'b0);
      tx <= 1'b1;
      wreg(`U0PR_IDX_PORT4_FUNC_LO, 8'h04);
      wreg(`U0PR_IDX_PORT4_DATA_OUT, 8'h00);
      repeat (3) @(posedge clk_in);
      pin_chk(p4_wire[3], 1'b0);
      pin_chk(p4_oe_n[2], 1'b1);
      wreg(`U0PR_IDX_PORT4_FUNC_LO, 8'h0C);
      for (int s = 0; s < 2; s++) begin
         for (int c = 0; c < 4; c++) begin
            wreg(`U0PR_IDX_SERIAL0_MODE0, s ? 8'h10 : 8'h00);
            wreg(`U0PR_IDX_PORT4_DRIVE_LO, {5'h01, c[0], 2'h0});
            wreg(`U0PR_IDX_PORT4_DRIVE_HI, {5'h01, c[1], 2'h0});
            wreg(`U0PR_IDX_PORT0_DRIVE_LO, {5'h00, c[0], 2'h0});
            wreg(`U0PR_IDX_PORT0_DRIVE_HI, {5'h00, c[1], 2'h0});
            wreg(`U0PR_IDX_PORT0_DATA_OUT, {5'h00, c[1], 2'h0});
            for (int v = 0; v < 2; v++) begin
               alt_lvl <= s ? v[0] : !v[0];
               def_lvl <= s ? !v[0] : v[0];
               repeat (8) @(posedge clk_in);
               pin_chk(rx_out, v[0]);
            end
         end
      end
      give_verdict();
   end
endmodule
